// *** logic/svc_service_state_pkg.sv ***
// Purpose: Shared constants and carriers for the slave maintenance logic
// Assumes: Three copies of every serial maintenance line, majority voted
// Notes: Bit positions are those of the outbound and inbound octet buses
package svc_service_state_pkg;

  // Deserialization register and address widths
  localparam int DESER_W = 4;
  localparam int ADDR_W = 3;
  localparam int ORDER_W = 3;

  // Last written bit says address (1) or order (0)
  localparam int KIND_BIT = 0;

  // Outbound octet bus positions: data, frame and shift copies
  localparam int OUT_DATA2 = 7;
  localparam int OUT_FRAME2 = 6;
  localparam int OUT_SHIFT1 = 5;
  localparam int OUT_DATA1 = 4;
  localparam int OUT_FRAME1 = 3;
  localparam int OUT_SHIFT0 = 2;
  localparam int OUT_DATA0 = 1;
  localparam int OUT_FRAME0 = 0;

  // Inbound octet bus positions; ack copy 2 sits on parity
  localparam int IN_UP2 = 7;
  localparam int IN_ECHO2 = 6;
  localparam int IN_ACK1 = 5;
  localparam int IN_UP1 = 4;
  localparam int IN_ECHO1 = 3;
  localparam int IN_ACK0 = 2;
  localparam int IN_UP0 = 1;
  localparam int IN_ECHO0 = 0;

  // Reset values
  localparam logic [DESER_W-1:0] DESER_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [7:0] OCTET_RST = 8'h00;

  // Voted and synchronised maintenance levels
  typedef struct packed {
    logic sel;
    logic hs;
    logic strobe;
    logic data;
    logic frame;
    logic shift;
  } svc_lines_s;

  // Order handed to the order decoder
  typedef struct packed {
    logic valid;
    logic [ORDER_W-1:0] code;
  } svc_order_s;

  // High-order field bit is the one shifted just before the kind bit
  function automatic logic [ADDR_W-1:0] field_of(input logic [DESER_W-1:0] d);
    field_of = {d[1], d[2], d[3]};
  endfunction : field_of

  function automatic logic vote3(input logic [2:0] l);
    vote3 = (l[0] & l[1]) | (l[0] & l[2]) | (l[1] & l[2]);
  endfunction : vote3

endpackage : svc_service_state_pkg

// *** logic/line_vote_sync.sv ***
// Purpose: Two-flop synchroniser on three line copies, then majority vote
// Assumes: Lines are static levels, asynchronous to clk
// Notes: A single line is fed as three equal copies
module line_vote_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Lines
  input wire logic [2:0] lines,
  output logic voted
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end
    else if (ce)
    begin
      meta_reg <= lines;
      sync_reg <= meta_reg;
    end
  end

  // Vote only after the second flop; one open wire is outvoted
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      voted <= 1'b0;
    else if (ce)
      voted <= svc_service_state_pkg::vote3(sync_reg);
  end

endmodule : line_vote_sync

// *** logic/serial_deser.sv ***
// Purpose: Deserialization register on the voted shift clock
// Assumes: Data and frame copies are set up to the shift clock edge
// Notes: Clock may stop outside frames; contents are then static
module serial_deser (
  // Link clock and reset
  input wire logic shift_clk,
  input wire logic rst_b,
  // Triplicated data and frame
  input wire logic [2:0] data_l,
  input wire logic [2:0] frame_l,
  // Held results
  output logic [svc_service_state_pkg::DESER_W-1:0] deser,
  output logic write_dir
);

  logic data_v;
  logic frame_v;

  assign data_v = svc_service_state_pkg::vote3(data_l);
  assign frame_v = svc_service_state_pkg::vote3(frame_l);

  always_ff @(posedge shift_clk or negedge rst_b)
  begin
    if (!rst_b)
      write_dir <= 1'b0;
    else if (!frame_v)
      write_dir <= data_v;
  end

  always_ff @(posedge shift_clk or negedge rst_b)
  begin
    if (!rst_b)
      deser <= svc_service_state_pkg::DESER_RST;
    else if (frame_v && write_dir)
      deser <= {deser[svc_service_state_pkg::DESER_W-2:0], data_v};
  end

endmodule : serial_deser

// *** logic/slave_service_state_ctrl.sv ***
// Purpose: Slave maintenance control for basic and serial service modes
// Assumes: REF_CLK 20 MHz; SHIFT_CLK is the voted shift line from the pads
// Notes: Order decoding and fault chain readout live outside this block
//
// Notes on behaviour
// - Restore answer waits for drivers released
// - Serial mode does basic functions too; here its reset needs frame as well as data
// - Service state releases drivers
// - Address match selects and enables drivers
// - Serial reset needs data and frame
// - Serial reset ends when either drops
// - Drivers stay released until restore
// - Majority vote of three copies
// - Frame end makes register readable
// - Shift data while frame active and direction bit set
// - Shift line clocks serial data
// - Inbound copies on inbound octet bus
// - Outbound copies on outbound octet bus
// - Basic reset follows data at strobe end
// - Basic reset release until restore state
// - Direction fixed before frame rises
// - Last bit picks address or order
// - Selection holds; ack until shift/strobe
module slave_service_state_ctrl (
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CE,
  // Link clock: voted shift line
  input wire logic SHIFT_CLK,
  // Control-out lines from the master
  input wire logic SEL_LINE,
  input wire logic HS_LINE,
  input wire logic STROBE_LINE,
  // Outbound octet bus
  input wire logic [7:0] OUT_OCTET,
  // Straps and functional side, same clock
  input wire logic SERIAL_MODE_EN,
  input wire logic [2:0] SLAVE_ADDR,
  input wire logic RESTORE_SEEN,
  input wire logic RESTORE_ORDER,
  // Inbound octet bus
  output logic [7:0] IN_OCTET,
  output logic IN_PARITY,
  output logic IN_OCTET_OE,
  // Slave control
  output logic DRV_ENABLE,
  output logic SLAVE_RESET,
  output logic SELECTED,
  output logic RESTORE_RESP_EN,
  output logic ORDER_VALID,
  output logic [2:0] ORDER_CODE
);

  svc_service_state_pkg::svc_lines_s lv;
  logic svc_on;
  logic strobe_prev_reg;
  logic frame_prev_reg;
  logic strobe_trail;
  logic frame_fall;
  logic serial_mode_reg;
  logic [2:0] my_addr_reg;
  logic strap_done_reg;
  logic [svc_service_state_pkg::DESER_W-1:0] deser_link;
  logic dir_link;
  logic [svc_service_state_pkg::DESER_W-1:0] deser_meta_reg;
  logic [svc_service_state_pkg::DESER_W-1:0] deser_sync_reg;
  logic dir_meta_reg;
  logic dir_sync_reg;
  logic rst_reg;
  logic rst_next;
  logic serial_rst_reg;
  logic hold_rel_reg;
  logic hold_rel_next;
  logic sel_reg;
  logic sel_next;
  logic ack_reg;
  logic ack_next;
  logic restore_pend_reg;
  svc_service_state_pkg::svc_order_s order_reg;
  svc_service_state_pkg::svc_order_s order_next;
  logic addr_frame;
  logic [2:0] field;

  line_vote_sync u_sel (
    .clk(REF_CLK), .rst_b(RST_B), .ce(CE),
    .lines({SEL_LINE, SEL_LINE, SEL_LINE}), .voted(lv.sel)
  );
  line_vote_sync u_hs (
    .clk(REF_CLK), .rst_b(RST_B), .ce(CE),
    .lines({HS_LINE, HS_LINE, HS_LINE}), .voted(lv.hs)
  );
  line_vote_sync u_strobe (
    .clk(REF_CLK), .rst_b(RST_B), .ce(CE),
    .lines({STROBE_LINE, STROBE_LINE, STROBE_LINE}), .voted(lv.strobe)
  );
  line_vote_sync u_data (
    .clk(REF_CLK), .rst_b(RST_B), .ce(CE),
    .lines({OUT_OCTET[svc_service_state_pkg::OUT_DATA2], OUT_OCTET[svc_service_state_pkg::OUT_DATA1],
            OUT_OCTET[svc_service_state_pkg::OUT_DATA0]}),
    .voted(lv.data)
  );
  line_vote_sync u_frame (
    .clk(REF_CLK), .rst_b(RST_B), .ce(CE),
    .lines({OUT_OCTET[svc_service_state_pkg::OUT_FRAME2], OUT_OCTET[svc_service_state_pkg::OUT_FRAME1],
            OUT_OCTET[svc_service_state_pkg::OUT_FRAME0]}),
    .voted(lv.frame)
  );
  line_vote_sync u_shift (
    .clk(REF_CLK), .rst_b(RST_B), .ce(CE),
    .lines({SHIFT_CLK, OUT_OCTET[svc_service_state_pkg::OUT_SHIFT1],
            OUT_OCTET[svc_service_state_pkg::OUT_SHIFT0]}),
    .voted(lv.shift)
  );

  serial_deser u_deser (
    .shift_clk(SHIFT_CLK),
    .rst_b(RST_B),
    .data_l({OUT_OCTET[svc_service_state_pkg::OUT_DATA2], OUT_OCTET[svc_service_state_pkg::OUT_DATA1],
             OUT_OCTET[svc_service_state_pkg::OUT_DATA0]}),
    .frame_l({OUT_OCTET[svc_service_state_pkg::OUT_FRAME2], OUT_OCTET[svc_service_state_pkg::OUT_FRAME1],
              OUT_OCTET[svc_service_state_pkg::OUT_FRAME0]}),
    .deser(deser_link),
    .write_dir(dir_link)
  );

  // Register is static once frame drops, so a plain word sync is safe
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      deser_meta_reg <= svc_service_state_pkg::DESER_RST;
      deser_sync_reg <= svc_service_state_pkg::DESER_RST;
      dir_meta_reg <= 1'b0;
      dir_sync_reg <= 1'b0;
    end
    else if (CE)
    begin
      deser_meta_reg <= deser_link;
      deser_sync_reg <= deser_meta_reg;
      dir_meta_reg <= dir_link;
      dir_sync_reg <= dir_meta_reg;
    end
  end

  // Straps caught after reset release
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      serial_mode_reg <= 1'b0;
      my_addr_reg <= svc_service_state_pkg::ADDR_RST;
      strap_done_reg <= 1'b0;
    end
    else if (CE && !strap_done_reg)
    begin
      serial_mode_reg <= SERIAL_MODE_EN;
      my_addr_reg <= SLAVE_ADDR;
      strap_done_reg <= 1'b1;
    end
  end

  assign svc_on = !lv.sel && !lv.hs && lv.strobe;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      strobe_prev_reg <= 1'b0;
      frame_prev_reg <= 1'b0;
    end
    else if (CE)
    begin
      strobe_prev_reg <= svc_on;
      frame_prev_reg <= lv.frame;
    end
  end

  assign strobe_trail = strobe_prev_reg && !svc_on && !lv.strobe;
  assign frame_fall = frame_prev_reg && !lv.frame && svc_on && dir_sync_reg;
  assign addr_frame = deser_sync_reg[svc_service_state_pkg::KIND_BIT];
  assign field = svc_service_state_pkg::field_of(deser_sync_reg);

  // Reset generation at strobe trailing edge
  always_comb
  begin
    rst_next = rst_reg;
    if (strobe_trail)
    begin
      if (serial_mode_reg)
        rst_next = lv.data && lv.frame;
      else
        rst_next = lv.data;
    end
    else if (rst_reg && serial_rst_reg && !(lv.data && lv.frame))
      rst_next = 1'b0;
    else if (rst_reg && !serial_rst_reg && !lv.data)
      rst_next = 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_reg <= 1'b0;
      serial_rst_reg <= 1'b0;
    end
    else if (CE)
    begin
      rst_reg <= rst_next;
      if (strobe_trail)
        serial_rst_reg <= serial_mode_reg;
    end
  end

  // Driver release hold after a reset
  always_comb
  begin
    hold_rel_next = hold_rel_reg;
    if (restore_pend_reg || (RESTORE_ORDER && sel_reg))
      hold_rel_next = 1'b0;
    if (strobe_trail && rst_next)
      hold_rel_next = 1'b1;
  end

  // Answer lands on the same edge as the driver hold release
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      hold_rel_reg <= 1'b0;
      restore_pend_reg <= 1'b0;
    end
    else if (CE)
    begin
      hold_rel_reg <= hold_rel_next;
      restore_pend_reg <= RESTORE_SEEN && hold_rel_reg && !rst_reg && !restore_pend_reg;
    end
  end

  // Selection and orders
  always_comb
  begin
    sel_next = sel_reg;
    ack_next = ack_reg;
    order_next = '0;
    // Ack ends on shift or strobe drop
    if (lv.shift || !lv.strobe)
      ack_next = 1'b0;
    if (!svc_on)
      sel_next = 1'b0;
    else if (frame_fall && serial_mode_reg)
    begin
      // Address or order by last bit
      if (addr_frame)
      begin
        sel_next = (field == my_addr_reg);
        if (field == my_addr_reg)
          ack_next = 1'b1;
      end
      else if (sel_reg)
      begin
        order_next.valid = 1'b1;
        order_next.code = field;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sel_reg <= 1'b0;
      ack_reg <= 1'b0;
      order_reg <= '0;
    end
    else if (CE)
    begin
      sel_reg <= sel_next;
      ack_reg <= ack_next;
      order_reg <= order_next;
    end
  end

  // Output flops
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      DRV_ENABLE <= 1'b1;
      SLAVE_RESET <= 1'b0;
      SELECTED <= 1'b0;
      RESTORE_RESP_EN <= 1'b0;
      ORDER_VALID <= 1'b0;
      ORDER_CODE <= 3'h0;
    end
    else if (CE)
    begin
      DRV_ENABLE <= svc_on ? sel_next : !hold_rel_next;
      SLAVE_RESET <= rst_next;
      SELECTED <= sel_next;
      RESTORE_RESP_EN <= restore_pend_reg;
      ORDER_VALID <= order_next.valid;
      ORDER_CODE <= order_next.code;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      IN_OCTET <= svc_service_state_pkg::OCTET_RST;
      IN_PARITY <= 1'b0;
      IN_OCTET_OE <= 1'b0;
    end
    else if (CE)
    begin
      // Fault chain readout is outside; serial up idles low
      IN_OCTET[svc_service_state_pkg::IN_UP2] <= 1'b0;
      IN_OCTET[svc_service_state_pkg::IN_UP1] <= 1'b0;
      IN_OCTET[svc_service_state_pkg::IN_UP0] <= 1'b0;
      IN_OCTET[svc_service_state_pkg::IN_ECHO2] <= lv.shift && sel_next;
      IN_OCTET[svc_service_state_pkg::IN_ECHO1] <= lv.shift && sel_next;
      IN_OCTET[svc_service_state_pkg::IN_ECHO0] <= lv.shift && sel_next;
      IN_OCTET[svc_service_state_pkg::IN_ACK1] <= ack_next;
      IN_OCTET[svc_service_state_pkg::IN_ACK0] <= ack_next;
      IN_PARITY <= ack_next;
      IN_OCTET_OE <= svc_on && sel_next;
    end
  end

endmodule : slave_service_state_ctrl

// *** verif/slave_service_state_ctrl_assertions.sv ***
// Purpose: Port checker for slave maintenance control
// Assumes: Lines reach outputs 4 REF_CLK edges later
// Notes: Bound to the control module
module slave_service_state_chk (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Lines in
  input wire logic SEL_LINE,
  input wire logic HS_LINE,
  input wire logic STROBE_LINE,
  input wire logic [7:0] OUT_OCTET,
  input wire logic RESTORE_SEEN,
  // Outputs
  input wire logic [7:0] IN_OCTET,
  input wire logic IN_PARITY,
  input wire logic IN_OCTET_OE,
  input wire logic DRV_ENABLE,
  input wire logic SLAVE_RESET,
  input wire logic SELECTED,
  input wire logic RESTORE_RESP_EN,
  input wire logic ORDER_VALID
);
  timeunit 1ns;
  timeprecision 100ps;
  logic svc;
  logic data_low;
  assign svc = !SEL_LINE && !HS_LINE && STROBE_LINE;
  // All copies low, so no vote can see data
  assign data_low = !(OUT_OCTET[7] | OUT_OCTET[4] | OUT_OCTET[1]);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  svc_release_a: assert property (svc [*6] ##0 !SELECTED |-> !DRV_ENABLE)
    else $error("drivers on in service");
  sel_ack_a: assert property ($rose(SELECTED) |-> DRV_ENABLE && IN_PARITY && IN_OCTET_OE)
    else $error("selection incomplete");
  oe_sel_a: assert property (IN_OCTET_OE |-> SELECTED)
    else $error("inbound on unselected");
  ack_copies_a: assert property (IN_PARITY == IN_OCTET[5] && IN_PARITY == IN_OCTET[2])
    else $error("ack copies differ");
  up_idle_a: assert property (!IN_OCTET[7] && !IN_OCTET[4] && !IN_OCTET[1])
    else $error("serial up not idle");
  echo_sel_a: assert property (IN_OCTET[6] |-> SELECTED && IN_OCTET[3] && IN_OCTET[0])
    else $error("echo on unselected");
  ack_clear_a: assert property (!STROBE_LINE [*6] |-> !IN_PARITY)
    else $error("ack kept after strobe");
  reset_off_a: assert property (data_low [*6] |-> !SLAVE_RESET)
    else $error("reset kept without data");
  reset_rel_a: assert property (SLAVE_RESET |-> !DRV_ENABLE)
    else $error("drivers on in reset");
  order_pulse_a: assert property (ORDER_VALID |=> !ORDER_VALID)
    else $error("order pulse too long");
  restore_lat_a: assert property (RESTORE_RESP_EN |-> $past(RESTORE_SEEN, 2) && DRV_ENABLE
    ##1 !RESTORE_RESP_EN)
    else $error("restore answer early");
  cover property ($rose(SELECTED));
  cover property (ORDER_VALID);
  cover property ($fell(SLAVE_RESET));
  cover property (RESTORE_RESP_EN);
  cover property (IN_OCTET[6]);
endmodule : slave_service_state_chk

bind slave_service_state_ctrl slave_service_state_chk i_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .SEL_LINE(SEL_LINE), .HS_LINE(HS_LINE),
  .STROBE_LINE(STROBE_LINE), .OUT_OCTET(OUT_OCTET), .RESTORE_SEEN(RESTORE_SEEN),
  .IN_OCTET(IN_OCTET), .IN_PARITY(IN_PARITY), .IN_OCTET_OE(IN_OCTET_OE),
  .DRV_ENABLE(DRV_ENABLE), .SLAVE_RESET(SLAVE_RESET), .SELECTED(SELECTED),
  .RESTORE_RESP_EN(RESTORE_RESP_EN), .ORDER_VALID(ORDER_VALID)
);

// *** verif/svc_master_model.sv ***
// Purpose: Maintenance master on the outbound lines
// Assumes: Link clock 6 ns, still outside transfers
// Notes: A fault flips data copy 2 only
module svc_master_model (
  // Control-out lines
  output logic sel_line,
  output logic hs_line,
  output logic strobe_line,
  // Outbound bus and link clock
  output logic [7:0] out_octet,
  output logic shift_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic data = 1'b0;
  logic frame = 1'b0;
  logic bad = 1'b0;
  initial
  begin
    sel_line = 1'b1;
    hs_line = 1'b0;
    strobe_line = 1'b0;
    shift_clk = 1'b0;
  end
  assign out_octet = {data ^ bad, frame, shift_clk, data, frame, shift_clk, data, frame};
  task automatic level(input logic s, input logic h, input logic t, input logic d, input logic f);
    sel_line <= s;
    hs_line <= h;
    strobe_line <= t;
    data <= d;
    frame <= f;
  endtask : level
  task automatic tick();
    #3 shift_clk = 1'b1;
    #3 shift_clk = 1'b0;
  endtask : tick
  // Direction, field low bit first, kind last
  // High-order field bit lands just before the kind bit
  task automatic xfer(input logic [2:0] f, input logic k, input logic w);
    logic [3:0] b;
    b = {k, f};
    #2 bad = w;
    data = 1'b1;
    tick();
    frame = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      data = b[i];
      tick();
    end
    frame = 1'b0;
    data = 1'b0;
    bad = 1'b0;
  endtask : xfer
endmodule : svc_master_model

// *** verif/tb.sv ***
// Purpose: Self-checking bench for slave maintenance control
// Assumes: Master model drives the outbound lines
// Notes: Address and wire faults from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ser_en = 1'b1;
  logic seen = 1'b0;
  logic rord = 1'b0;
  logic [2:0] own = 3'h0;
  logic [2:0] ov_code = 3'h0;
  logic [2:0] code, a;
  logic [7:0] octo, octi;
  logic sel, hs, stb, sclk, par, oe, drv, srst, sl, rsp, ov, e;
  int errors = 0;
  int comparisons = 0;
  int ov_n = 0;
  int rp_n = 0;
  int n;
  int seed = 32'h28c6a3d1;
  always #25 ref_clk = ~ref_clk;
  // Pulses counted mid-cycle, clear of the launch edge
  always @(negedge ref_clk)
  begin
    ov_n += int'(ov === 1'b1);
    rp_n += int'(rsp === 1'b1);
    if (ov === 1'b1)
      ov_code = code;
  end
  svc_master_model i_mst (.sel_line(sel), .hs_line(hs), .strobe_line(stb),
    .out_octet(octo), .shift_clk(sclk));
  slave_service_state_ctrl i_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .CE(1'b1),
    .SHIFT_CLK(sclk), .SEL_LINE(sel), .HS_LINE(hs), .STROBE_LINE(stb),
    .OUT_OCTET(octo), .SERIAL_MODE_EN(ser_en), .SLAVE_ADDR(own),
    .RESTORE_SEEN(seen), .RESTORE_ORDER(rord), .IN_OCTET(octi), .IN_PARITY(par),
    .IN_OCTET_OE(oe), .DRV_ENABLE(drv), .SLAVE_RESET(srst), .SELECTED(sl),
    .RESTORE_RESP_EN(rsp), .ORDER_VALID(ov), .ORDER_CODE(code));
  task automatic end_sim();
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t flag %b exp %b", $time, got, exp);
    end
  endtask : chk
  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t code %h exp %h", $time, got, exp);
    end
  endtask : chk3
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task automatic lv(input logic s, input logic h, input logic t, input logic d, input logic f);
    @(posedge ref_clk);
    i_mst.level(s, h, t, d, f);
  endtask : lv
  function automatic logic rst_exp(input logic s, input logic d, input logic f);
    return s ? d & f : d;
  endfunction : rst_exp
  task automatic serial_part();
    a = own ^ (3'($random(seed)) | 3'h1);
    i_mst.xfer(a, 1'b1, 1'b0);
    cyc(8);
    chk(sl, 1'b0);
    i_mst.xfer(own, 1'b1, 1'b1);
    cyc(8);
    chk(sl, 1'b1);
    chk(drv, 1'b1);
    chk(par, 1'b1);
    chk(oe, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      n = ov_n;
      i_mst.xfer(3'(c), 1'b0, 1'($random(seed)));
      cyc(8);
      chk(ov_n == n + 1, 1'b1);
      chk3(ov_code, 3'(c));
    end
    chk(sl, 1'b1);
  endtask : serial_part
  task automatic decide(input logic s, input logic d, input logic f);
    e = rst_exp(s, d, f);
    lv(1'b0, 1'b0, 1'b1, d, f);
    cyc(8);
    lv(1'b0, 1'b0, 1'b0, d, f);
    cyc(8);
    chk(srst, e);
    chk(drv, !e);
    chk(sl, 1'b0);
    chk(par, 1'b0);
    lv(1'b0, 1'b0, 1'b0, s & d, !s & f);
    cyc(8);
    chk(srst, 1'b0);
    chk(drv, !e);
    n = rp_n;
    @(posedge ref_clk);
    seen <= 1'b1;
    cyc(5);
    chk(drv, 1'b1);
    chk(rp_n != n, e);
    @(posedge ref_clk);
    seen <= 1'b0;
  endtask : decide
  // Serial reset, then drivers restored by order while selected
  task automatic order_restore();
    lv(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    cyc(8);
    lv(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(8);
    lv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk(drv, 1'b0);
    lv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(8);
    i_mst.xfer(own, 1'b1, 1'b0);
    cyc(8);
    chk(sl, 1'b1);
    @(posedge ref_clk);
    rord <= 1'b1;
    @(posedge ref_clk);
    rord <= 1'b0;
    lv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk(drv, 1'b1);
    chk(srst, 1'b0);
  endtask : order_restore
  task automatic run_mode(input logic s);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    ser_en <= s;
    cyc(3);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(2);
    chk(drv, 1'b1);
    chk(srst, 1'b0);
    lv(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(8);
    chk(drv, 1'b1);
    lv(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(8);
    chk(drv, 1'b1);
    lv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(8);
    chk(drv, 1'b0);
    if (s)
      serial_part();
    for (int k = 0; k < 4; k++)
      decide(s, k[1], k[0]);
    if (s)
      order_restore();
  endtask : run_mode
  initial
  begin
    own = 3'($random(seed));
    run_mode(1'b1);
    run_mode(1'b0);
    end_sim();
  end
  // Run needs under 1000 cycles
  initial
  begin
    #150000;
    errors++;
    end_sim();
  end
endmodule : tb
